// File: dv/fswp_flash_status_write_protect_tb.sv
// self-checking bench for the status and write-protect block
// assumes the host model drives the link; busy length shortened to 4 clk
`timescale 1ns/1ns
`define CHK(x, y) begin checks_done++; if ((x) !== (y)) begin fails++; \
  $display("wrong value at %0t: got %h exp %h", $time, x, y); end end
module fswp_flash_status_write_protect_tb;
  import fswp_pkg::*;
  logic clk_i, rst_i, nv_rst_i, sclk, cs_n, si, wg_n, so_o, so_oe_o, op_start_o, cmd_refused_o;
  logic quad_enable_o, dummy_cycle_select_o, write_busy_o;
  fswp_op_t op_kind_o;
  logic [23:0] op_addr_o, a;
  logic [7:0] status_protect_byte_o, status_config_byte_o, status_drive_byte_o;
  logic [1:0] drive_strength_o;
  logic [2:0] secure_area_lock_o;
  logic [3:0] q[$];
  logic [7:0] ec[3] = '{CMD_WIPE_4K, CMD_WIPE_32K, CMD_WIPE_64K};
  fswp_op_t ek[3] = '{OP_W4K, OP_W32K, OP_W64K};
  int fails = 0, checks_done = 0;
  fswp_flash_status_write_protect #(.OP_CYCLES(4)) i_fswp_flash_status_write_protect (.clk_i(clk_i),
    .rst_i(rst_i), .nv_rst_i(nv_rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si), .write_guard_n_i(wg_n),
    .so_o(so_o), .so_oe_o(so_oe_o), .op_start_o(op_start_o), .op_kind_o(op_kind_o), .op_addr_o(op_addr_o),
    .cmd_refused_o(cmd_refused_o), .status_protect_byte_o(status_protect_byte_o),
    .status_config_byte_o(status_config_byte_o), .status_drive_byte_o(status_drive_byte_o),
    .quad_enable_o(quad_enable_o), .drive_strength_o(drive_strength_o),
    .dummy_cycle_select_o(dummy_cycle_select_o), .secure_area_lock_o(secure_area_lock_o),
    .write_busy_o(write_busy_o));
  fswp_host_model i_fswp_host_model (.clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so_o),
    .so_oe_i(so_oe_o));
  // ****************
  // helpers
  // ****************
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic end_sim();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic frm(input logic [63:0] d, input int n);
    logic [7:0] r;
    i_fswp_host_model.frame(d, n, r);
  endtask : frm
  task automatic rds(input logic [7:0] c, input logic [7:0] e);
    logic [7:0] r;
    i_fswp_host_model.frame({c, 56'h0}, 16, r);
    `CHK(r, e)
  endtask : rds
  // write enable first, so only the protection decides the outcome
  task automatic op(input logic [7:0] c, input logic [23:0] ad, input int n, input bit ok, input fswp_op_t k);
    frm({CMD_WR_EN, 56'h0}, 8);
    q.push_back(ok ? {1'b1, k} : 4'h0);
    frm({c, ad, 32'h0}, n);
    `CHK(write_busy_o, 1'b0)
  endtask : op
  task automatic ws(input logic [7:0] c, input logic [7:0] v, input bit ok);
    op(c, {v, 16'h0}, 16, ok, OP_STATUS);
  endtask : ws
  // power-up pulse only; all non-volatile bits but a lock-down guard1 must survive it
  task automatic por();
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask : por
  // each launch or refusal consumes the oldest expected note
  initial begin : mon
    logic [3:0] e;
    forever begin
      @(posedge clk_i);
      #2;
      if (op_start_o === 1'b1 || cmd_refused_o === 1'b1) begin
        e = q.size() > 0 ? q.pop_front() : 4'hf;
        `CHK({op_start_o, op_start_o ? op_kind_o : OP_NONE}, e)
        `CHK(write_busy_o, op_start_o)
        `CHK(status_protect_byte_o[P_LATCH], 1'b0)
      end
    end
  end
  // watchdog: a hung frame still reaches the verdict; the tests need just under 0.3 ms, a little under a third of this span
  initial begin
    #1000000;
    fails++;
    end_sim();
  end
  // ****************
  // tests
  // ****************
  initial begin
    rst_i = 1'b1;
    nv_rst_i = 1'b1;
    wg_n = 1'b1;
    void'($urandom(32'h410c));
    repeat (6) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    nv_rst_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK({status_protect_byte_o, status_config_byte_o, status_drive_byte_o}, 24'h000020)
    rds(CMD_RD_S3, 8'h20);
    q.push_back(4'h0);
    frm({CMD_WS_1, 8'h04, 48'h0}, 16);
    frm({CMD_WR_EN, 56'h0}, 8);
    rds(CMD_RD_S1, 8'h02);
    frm({CMD_WR_DIS, 56'h0}, 8);
    rds(CMD_RD_S1, 8'h00);
    frm({CMD_WR_EN, 56'h0}, 8);
    frm({CMD_RST_ARM, 56'h0}, 8);
    frm({CMD_RST_GO, 56'h0}, 8);
    rds(CMD_RD_S1, 8'h00);
    // top 64 KB guarded: every erase size refused there, accepted low
    ws(CMD_WS_1, 8'h04, 1'b1);
    `CHK(status_protect_byte_o, 8'h04)
    foreach (ec[i]) begin
      op(ec[i], 24'h3ff000, 32, 1'b0, OP_NONE);
      op(ec[i], 24'h000000, 32, 1'b1, ek[i]);
    end
    for (int i = 0; i < 4; i++) begin
      a = 24'($urandom % 32'h3f0000) & 24'h3fff00;
      op(CMD_PROG, a, 40, 1'b1, OP_PROG);
      `CHK(op_addr_o, a)
    end
    op(CMD_PROG, 24'h3fff00, 40, 1'b0, OP_NONE);
    op(CMD_CHIP_A, 24'h0, 8, 1'b0, OP_NONE);
    ws(CMD_WS_1, 8'h44, 1'b1);
    op(CMD_PROG, 24'h3ff000, 40, 1'b0, OP_NONE);
    op(CMD_PROG, 24'h3fef00, 40, 1'b1, OP_PROG);
    ws(CMD_WS_1, 8'h04, 1'b1);
    ws(CMD_WS_2, 8'h40, 1'b1);
    op(CMD_PROG, 24'h000100, 40, 1'b0, OP_NONE);
    op(CMD_PROG, 24'h3f0000, 40, 1'b1, OP_PROG);
    ws(CMD_WS_1, 8'h1c, 1'b1);
    op(CMD_CHIP_B, 24'h0, 8, 1'b1, OP_CHIP);
    ws(CMD_WS_1, 8'h00, 1'b1);
    op(CMD_PROG, 24'h3fff00, 40, 1'b0, OP_NONE);
    op(CMD_CHIP_A, 24'h0, 8, 1'b0, OP_NONE);
    ws(CMD_WS_2, 8'h00, 1'b1);
    op(CMD_CHIP_A, 24'h0, 8, 1'b1, OP_CHIP);
    // hardware mode follows the pin unless quad mode takes it over
    ws(CMD_WS_1, 8'h80, 1'b1);
    wg_n = 1'b0;
    ws(CMD_WS_1, 8'h84, 1'b0);
    `CHK(status_protect_byte_o, 8'h80)
    wg_n = 1'b1;
    ws(CMD_WS_2, 8'h02, 1'b1);
    // the pin is driven by the bench, never tied, so quad mode is safe
    wg_n = 1'b0;
    ws(CMD_WS_1, 8'h84, 1'b1);
    `CHK(quad_enable_o, 1'b1)
    ws(CMD_WS_2, 8'h00, 1'b1);
    ws(CMD_WS_1, 8'h00, 1'b0);
    wg_n = 1'b1;
    ws(CMD_WS_1, 8'h00, 1'b1);
    wg_n = 1'b0;
    ws(CMD_WS_1, 8'h08, 1'b1);
    ws(CMD_WS_2, 8'h01, 1'b1);
    ws(CMD_WS_1, 8'h00, 1'b0);
    ws(CMD_WS_3, 8'h41, 1'b0);
    por();
    `CHK({status_protect_byte_o, status_config_byte_o}, 16'h0800)
    ws(CMD_WS_2, 8'h08, 1'b1);
    ws(CMD_WS_2, 8'h00, 1'b1);
    `CHK(secure_area_lock_o, 3'h1)
    ws(CMD_WS_3, 8'h41, 1'b1);
    `CHK({drive_strength_o, dummy_cycle_select_o}, 3'h5)
    rds(CMD_RD_S3, 8'h41);
    rds(CMD_RD_S2, 8'h08);
    ws(CMD_WS_1, 8'h80, 1'b1);
    wg_n = 1'b1;
    ws(CMD_WS_2, 8'h01, 1'b1);
    por();
    ws(CMD_WS_1, 8'h00, 1'b0);
    rds(CMD_RD_S1, 8'h80);
    repeat (4) @(posedge clk_i);
    `CHK(q.size(), 0)
    end_sim();
  end
endmodule : fswp_flash_status_write_protect_tb

// File: dv/fswp_host_model.sv
// host-side model of the serial link: whole-byte frames, msb first
// assumes clk_i is the device clock; sclk idles low (mode 0) between frames
`timescale 1ns/1ns
module fswp_host_model (
  // clock
  input wire logic clk_i,
  // link pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_i
);
  // ****************
  // frame driver
  // ****************
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  // half of a 160 ns sclk period, launched just after a clk edge
  task automatic half();
    repeat (4) @(posedge clk_i);
    #1;
  endtask : half
  // sends n bits of d from its msb; so bits after the first byte land in rd
  task automatic frame(input logic [63:0] d, input int n, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk_i);
    #1;
    cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      si_o = d[63-i];
      half();
      sclk_o = 1'b1;
      // an undriven so must never pass for data
      if (i >= 8) rd = {rd[6:0], so_oe_i ? so_i : 1'bx};
      half();
      sclk_o = 1'b0;
    end
    half();
    cs_n_o = 1'b1;
    // released line shows the inverse, not a stale bit
    si_o = ~si_o;
    // covers execution delay, busy span and the deselect gap
    repeat (12) @(posedge clk_i);
    #1;
  endtask : frame
endmodule : fswp_host_model

// File: verilog/fswp_flash_status_write_protect.sv
// status registers and write protection of a serial nor flash
// assumes link pins are asynchronous; rst_i is power-up, nv_rst_i is factory init
`timescale 1ns/1ns
module fswp_flash_status_write_protect #(
  parameter int OP_CYCLES = 64
) (
  // clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic nv_rst_i,
  // serial link pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic write_guard_n_i,
  output logic so_o,
  output logic so_oe_o,
  // launch of array operations
  output logic op_start_o,
  output fswp_pkg::fswp_op_t op_kind_o,
  output logic [fswp_pkg::ADDR_W-1:0] op_addr_o,
  output logic cmd_refused_o,
  // state seen by the rest of the device
  output logic [7:0] status_protect_byte_o,
  output logic [7:0] status_config_byte_o,
  output logic [7:0] status_drive_byte_o,
  output logic quad_enable_o,
  output logic [1:0] drive_strength_o,
  output logic dummy_cycle_select_o,
  output logic [2:0] secure_area_lock_o,
  output logic write_busy_o
);
  import fswp_pkg::*;

  localparam int CW = $clog2(OP_CYCLES + 1);

  // refuse counts the busy counter cannot hold
  if (OP_CYCLES < 1 || OP_CYCLES > 65535) begin : g_bad_cycles
    $error("OP_CYCLES out of range");
  end

  // ****************************************
  // link sampling and byte assembly
  // ****************************************
  logic [2:0] sclk_q, next_sclk_q, csn_q, next_csn_q;
  logic [1:0] si_q, next_si_q, wp_q, next_wp_q;
  logic [2:0] bit_cnt, next_bit_cnt, byte_cnt, next_byte_cnt;
  logic [6:0] shreg, next_shreg;
  logic [7:0] cmd, next_cmd, wdata, next_wdata, out_sh, next_out_sh;
  logic [23:0] addr, next_addr;
  logic so, next_so, so_oe, next_so_oe;
  logic sclk_rise, sclk_fall, cs_act, cs_end;
  logic [7:0] byte_v, rd_cmd, sb1, sb2, sb3;

  // edge detect reads only the second and third stages
  assign sclk_rise = sclk_q[1] & ~sclk_q[2];
  assign sclk_fall = ~sclk_q[1] & sclk_q[2];
  assign cs_act = ~csn_q[1];
  assign cs_end = csn_q[1] & ~csn_q[2];

  // shift in on rising edges, shift out on falling edges
  always_comb begin
    next_sclk_q = {sclk_q[1:0], sclk_i};
    next_csn_q = {csn_q[1:0], cs_n_i};
    next_si_q = {si_q[0], si_i};
    next_wp_q = {wp_q[0], write_guard_n_i};
    next_bit_cnt = bit_cnt;
    next_byte_cnt = byte_cnt;
    next_shreg = shreg;
    next_cmd = cmd;
    next_wdata = wdata;
    next_addr = addr;
    next_out_sh = out_sh;
    next_so = so;
    byte_v = {shreg, si_q[1]};
    rd_cmd = (byte_cnt == 3'h0) ? byte_v : cmd;
    if (!cs_act) begin
      next_bit_cnt = 3'h0;
      next_byte_cnt = 3'h0;
    end else if (sclk_rise) begin
      next_shreg = byte_v[6:0];
      next_bit_cnt = bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        if (byte_cnt == 3'h0) begin
          next_cmd = byte_v;
        end else if (byte_cnt <= 3'h3) begin
          next_addr = {addr[15:0], byte_v};
        end
        if (byte_cnt == 3'h1) begin
          next_wdata = byte_v;
        end
        if (byte_cnt != LEN_MAX) begin
          next_byte_cnt = byte_cnt + 3'h1;
        end
        // reload keeps a status read repeating byte after byte
        unique case (rd_cmd)
          CMD_RD_S1: next_out_sh = sb1;
          CMD_RD_S2: next_out_sh = sb2;
          CMD_RD_S3: next_out_sh = sb3;
          default: next_out_sh = 8'h00;
        endcase
      end
    end else if (sclk_fall) begin
      next_so = out_sh[7];
      next_out_sh = {out_sh[6:0], 1'b0};
    end
    next_so_oe = cs_act && byte_cnt != 3'h0 &&
                 (cmd == CMD_RD_S1 || cmd == CMD_RD_S2 || cmd == CMD_RD_S3);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_q <= 3'h0;
      csn_q <= 3'h7;
      si_q <= 2'h0;
      wp_q <= 2'h3;
      bit_cnt <= 3'h0;
      byte_cnt <= 3'h0;
      shreg <= 7'h00;
      cmd <= 8'h00;
      wdata <= 8'h00;
      addr <= 24'h000000;
      out_sh <= 8'h00;
      so <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      sclk_q <= next_sclk_q;
      csn_q <= next_csn_q;
      si_q <= next_si_q;
      wp_q <= next_wp_q;
      bit_cnt <= next_bit_cnt;
      byte_cnt <= next_byte_cnt;
      shreg <= next_shreg;
      cmd <= next_cmd;
      wdata <= next_wdata;
      addr <= next_addr;
      out_sh <= next_out_sh;
      so <= next_so;
      so_oe <= next_so_oe;
    end
  end

  // ****************************************
  // protection decode
  // ****************************************
  logic write_enable_latch, next_wel, armed, next_armed, pwr_fix, next_pwr_fix;
  logic [CW-1:0] busy_cnt, next_busy_cnt;
  logic op_start, next_op_start, refused, next_refused;
  fswp_op_t op_kind, next_op_kind;
  logic [23:0] op_addr, next_op_addr;
  logic [4:0] area, next_area;
  logic guard0, next_guard0, guard1, next_guard1, quad, next_quad;
  logic compl, next_compl, dummy, next_dummy;
  logic [2:0] lock, next_lock;
  logic [1:0] drive, next_drive, gmode;
  logic busy, exec, wp_high, sr_unlocked, is_ws, is_wipe, is_chip, is_prog;
  logic wr_class, tgt_guard, chip_ok, sr_go, arr_go, chip_go;
  logic [23:0] last_addr, unit_mask;
  fswp_op_t arr_kind;

  // guarded region: one end of the array, inverted by the complement bit
  function automatic logic in_guard(input logic [ARR_W-1:0] a, input logic [4:0] ag, input logic cm);
    logic [4:0] sh;
    logic [22:0] size;
    logic hit;
    sh = 5'h0;
    size = 23'h0;
    hit = 1'b0;
    if (ag[2:0] == 3'h7) begin
      hit = 1'b1;
    end else if (ag[2:0] != 3'h0) begin
      // small-sector patterns stop growing at 32 KB
      if (ag[4]) begin
        sh = (ag[2:0] > 3'h4) ? 5'h3 : {2'h0, ag[2:0]} - 5'h1;
      end else begin
        sh = {2'h0, ag[2:0]} + 5'h3;
      end
      size = 23'h1 << (5'(UNIT_SH) + sh);
      hit = ag[3] ? ({1'b0, a} < size) : ({1'b0, a} >= ARR_BYTES - size);
    end
    return hit ^ cm;
  endfunction : in_guard

  assign busy = busy_cnt != '0;
  assign exec = cs_end && bit_cnt == 3'h0 && byte_cnt != 3'h0;
  assign wp_high = quad | wp_q[1];
  assign gmode = {guard1, guard0};
  // modes 10 and 11 never unlock; 01 follows the pin unless quad is set
  assign sr_unlocked = (gmode == GM_SOFT) |
                       (gmode == GM_HW & wp_high);
  assign is_ws = byte_cnt == LEN_WS && (cmd == CMD_WS_1 || cmd == CMD_WS_2 || cmd == CMD_WS_3);
  assign is_prog = cmd == CMD_PROG && byte_cnt >= LEN_PROG;
  assign is_wipe = byte_cnt == LEN_WIPE &&
                   (cmd == CMD_WIPE_4K || cmd == CMD_WIPE_32K || cmd == CMD_WIPE_64K);
  assign is_chip = byte_cnt == LEN_ONE && (cmd == CMD_CHIP_A || cmd == CMD_CHIP_B);
  assign wr_class = is_ws | is_prog | is_wipe | is_chip;
  assign unit_mask = is_prog ? MASK_PAGE : cmd == CMD_WIPE_4K ? MASK_4K :
                     cmd == CMD_WIPE_32K ? MASK_32K : MASK_64K;
  assign arr_kind = is_prog ? OP_PROG : cmd == CMD_WIPE_4K ? OP_W4K :
                    cmd == CMD_WIPE_32K ? OP_W32K : OP_W64K;
  assign last_addr = addr | unit_mask;
  // region is contiguous, so both ends of the unit decide overlap
  assign tgt_guard = in_guard(addr[ARR_W-1:0], area, compl) |
                     in_guard(last_addr[ARR_W-1:0], area, compl);
  assign chip_ok = (area[2:0] == 3'h0 & ~compl) | (area[2:0] == 3'h7 & compl);
  // every write needs the latch and an idle device
  assign sr_go = exec & is_ws & write_enable_latch & ~busy & sr_unlocked;
  assign arr_go = exec & (is_prog | is_wipe) & write_enable_latch & ~busy & ~tgt_guard;
  assign chip_go = exec & is_chip & write_enable_latch & ~busy & chip_ok;

  // ****************************************
  // latch, busy timer and launch
  // ****************************************
  always_comb begin
    next_wel = write_enable_latch;
    next_armed = armed;
    next_pwr_fix = 1'b0;
    next_busy_cnt = busy ? busy_cnt - CW'(1) : busy_cnt;
    next_op_start = sr_go | arr_go | chip_go;
    next_op_kind = op_kind;
    next_op_addr = op_addr;
    next_refused = exec & wr_class & ~(sr_go | arr_go | chip_go);
    if (exec && !busy) begin
      next_armed = cmd == CMD_RST_ARM && byte_cnt == LEN_ONE;
      if (cmd == CMD_WR_EN && byte_cnt == LEN_ONE) begin
        next_wel = 1'b1;
      end
      if ((wr_class && write_enable_latch) || (byte_cnt == LEN_ONE &&
          (cmd == CMD_WR_DIS || (cmd == CMD_RST_GO && armed)))) begin
        next_wel = 1'b0;
      end
    end
    if (next_op_start) begin
      next_busy_cnt = CW'(OP_CYCLES);
      next_op_kind = sr_go ? OP_STATUS : chip_go ? OP_CHIP : arr_kind;
      next_op_addr = addr;
    end
  end

  // power-up clears the volatile bits
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      write_enable_latch <= 1'b0;
      armed <= 1'b0;
      pwr_fix <= 1'b1;
      busy_cnt <= '0;
      op_start <= 1'b0;
      op_kind <= OP_NONE;
      op_addr <= 24'h000000;
      refused <= 1'b0;
    end else begin
      write_enable_latch <= next_wel;
      armed <= next_armed;
      pwr_fix <= next_pwr_fix;
      busy_cnt <= next_busy_cnt;
      op_start <= next_op_start;
      op_kind <= next_op_kind;
      op_addr <= next_op_addr;
      refused <= next_refused;
    end
  end

  // ****************************************
  // non-volatile status bits
  // ****************************************
  always_comb begin
    next_area = area;
    next_guard0 = guard0;
    next_guard1 = guard1;
    next_quad = quad;
    next_compl = compl;
    next_lock = lock;
    next_drive = drive;
    next_dummy = dummy;
    // first clock after power-up releases the lock-down mode
    if (pwr_fix && gmode == GM_LOCKDOWN) begin
      next_guard1 = 1'b0;
    end
    if (sr_go) begin
      unique case (cmd)
        CMD_WS_1: begin
          next_area = wdata[P_AREA +: 5];
          next_guard0 = wdata[P_GUARD0];
        end
        CMD_WS_2: begin
          next_guard1 = wdata[C_GUARD1];
          next_quad = wdata[C_QUAD];
          next_compl = wdata[C_COMPL];
          next_lock = lock | wdata[C_LOCK +: 3];
        end
        default: begin
          next_drive = wdata[D_DRIVE +: 2];
          next_dummy = wdata[D_DUMMY];
        end
      endcase
    end
  end

  // held across power-up except a lock-down guard1; otherwise only factory init restores defaults
  always_ff @(posedge clk_i or posedge nv_rst_i) begin
    if (nv_rst_i) begin
      area <= 5'h00;
      guard0 <= 1'b0;
      guard1 <= 1'b0;
      quad <= 1'b0;
      compl <= 1'b0;
      lock <= 3'h0;
      drive <= DRIVE_RST;
      dummy <= 1'b0;
    end else begin
      area <= next_area;
      guard0 <= next_guard0;
      guard1 <= next_guard1;
      quad <= next_quad;
      compl <= next_compl;
      lock <= next_lock;
      drive <= next_drive;
      dummy <= next_dummy;
    end
  end

  // ****************************************
  // status bytes and outputs
  // ****************************************
  // suspend is not built here, so both pause bits read zero
  always_comb begin
    sb1 = 8'h00;
    sb2 = 8'h00;
    sb3 = 8'h00;
    sb1[P_BUSY] = busy;
    sb1[P_LATCH] = write_enable_latch;
    sb1[P_AREA +: 5] = area;
    sb1[P_GUARD0] = guard0;
    sb2[C_GUARD1] = guard1;
    sb2[C_QUAD] = quad;
    sb2[C_PPAUSE] = 1'b0;
    sb2[C_LOCK +: 3] = lock;
    sb2[C_COMPL] = compl;
    sb2[C_EPAUSE] = 1'b0;
    sb3[D_DRIVE +: 2] = drive;
    sb3[D_DUMMY] = dummy;
  end

  assign so_o = so;
  assign so_oe_o = so_oe;
  assign op_start_o = op_start;
  assign op_kind_o = op_kind;
  assign op_addr_o = op_addr;
  assign cmd_refused_o = refused;
  assign status_protect_byte_o = sb1;
  assign status_config_byte_o = sb2;
  assign status_drive_byte_o = sb3;
  assign quad_enable_o = quad;
  assign drive_strength_o = drive;
  assign dummy_cycle_select_o = dummy;
  assign secure_area_lock_o = lock;
  assign write_busy_o = busy;

  // ****************************************
  // checks
  // ****************************************
  logic [CW:0] busy_age;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_age <= '0;
    end else begin
      busy_age <= busy ? busy_age + (CW+1)'(1) : '0;
    end
  end

  sequence s_write_frame;
    exec && wr_class;
  endsequence
  sequence s_launch;
    ##1 op_start_o;
  endsequence

  property p_busy_report;
    @(posedge clk_i) disable iff (rst_i) s_launch |-> write_busy_o && status_protect_byte_o[P_BUSY];
  endproperty
  a_busy_report: assert property (p_busy_report) else $error("busy not shown");
  property p_busy_bound;
    @(posedge clk_i) disable iff (rst_i) busy_age <= (CW+1)'(OP_CYCLES);
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("busy too long");
  property p_latch_gate;
    @(posedge clk_i) disable iff (rst_i) (s_write_frame and !write_enable_latch) |-> not s_launch;
  endproperty
  a_latch_gate: assert property (p_latch_gate) else $error("write without latch");
  property p_region;
    @(posedge clk_i) disable iff (rst_i) (s_write_frame and (is_prog || is_wipe) && tgt_guard) |=> cmd_refused_o;
  endproperty
  a_region: assert property (p_region) else $error("guarded target accepted");
  property p_chip;
    @(posedge clk_i) disable iff (rst_i) op_start_o && op_kind_o == OP_CHIP |-> $past(chip_ok);
  endproperty
  a_chip: assert property (p_chip) else $error("chip erase while guarded");
  property p_hw_lock;
    @(posedge clk_i) disable iff (rst_i) exec && is_ws && gmode == GM_HW && !wp_q[1] && !quad
      |=> $stable(status_protect_byte_o[7:2]) && !op_start_o;
  endproperty
  a_hw_lock: assert property (p_hw_lock) else $error("status written while pin low");
  property p_lockdown;
    @(posedge clk_i) disable iff (rst_i) gmode[1] && !pwr_fix |=> $stable(area) && gmode == $past(gmode);
  endproperty
  a_lockdown: assert property (p_lockdown) else $error("locked status changed");
  property p_power_fix;
    @(posedge clk_i) disable iff (rst_i) pwr_fix && gmode == GM_LOCKDOWN |=> gmode == GM_SOFT;
  endproperty
  a_power_fix: assert property (p_power_fix) else $error("lock-down kept after power-up");
  property p_otp;
    @(posedge clk_i) disable iff (rst_i || nv_rst_i) ##1 (lock & $past(lock)) == $past(lock);
  endproperty
  a_otp: assert property (p_otp) else $error("lock bit cleared");
  property p_latch_set;
    @(posedge clk_i) disable iff (rst_i) exec && !busy && cmd == CMD_WR_EN && byte_cnt == LEN_ONE |=> write_enable_latch [*2];
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("enable did not set latch");
  property p_powerup;
    @(posedge clk_i) disable iff (rst_i) pwr_fix |-> !write_enable_latch && !busy && !sb2[C_EPAUSE];
  endproperty
  a_powerup: assert property (p_powerup) else $error("volatile bit set at power-up");
endmodule : fswp_flash_status_write_protect

// File: verilog/fswp_pkg.sv
// package for the flash status and write-protect block
// assumes a 4 MB array behind a serial command link
package fswp_pkg;
  localparam int ADDR_W = 24;
  localparam int ARR_W = 22;
  localparam logic [22:0] ARR_BYTES = 23'h400000;
  localparam int UNIT_SH = 12;
  // command codes
  localparam logic [7:0] CMD_WR_EN = 8'h06;
  localparam logic [7:0] CMD_WR_DIS = 8'h04;
  localparam logic [7:0] CMD_RD_S1 = 8'h05;
  localparam logic [7:0] CMD_RD_S2 = 8'h35;
  localparam logic [7:0] CMD_RD_S3 = 8'h15;
  localparam logic [7:0] CMD_WS_1 = 8'h01;
  localparam logic [7:0] CMD_WS_2 = 8'h31;
  localparam logic [7:0] CMD_WS_3 = 8'h11;
  localparam logic [7:0] CMD_PROG = 8'h02;
  localparam logic [7:0] CMD_WIPE_4K = 8'h20;
  localparam logic [7:0] CMD_WIPE_32K = 8'h52;
  localparam logic [7:0] CMD_WIPE_64K = 8'hd8;
  localparam logic [7:0] CMD_CHIP_A = 8'h60;
  localparam logic [7:0] CMD_CHIP_B = 8'hc7;
  localparam logic [7:0] CMD_RST_ARM = 8'h66;
  localparam logic [7:0] CMD_RST_GO = 8'h99;
  // byte counts of complete frames
  localparam logic [2:0] LEN_ONE = 3'h1;
  localparam logic [2:0] LEN_WS = 3'h2;
  localparam logic [2:0] LEN_WIPE = 3'h4;
  localparam logic [2:0] LEN_PROG = 3'h5;
  localparam logic [2:0] LEN_MAX = 3'h7;
  // unit masks for last-address checks
  localparam logic [23:0] MASK_PAGE = 24'h0000ff;
  localparam logic [23:0] MASK_4K = 24'h000fff;
  localparam logic [23:0] MASK_32K = 24'h007fff;
  localparam logic [23:0] MASK_64K = 24'h00ffff;
  // field positions inside the three status bytes
  localparam int P_BUSY = 0, P_LATCH = 1, P_AREA = 2, P_GUARD0 = 7;
  localparam int C_GUARD1 = 0, C_QUAD = 1, C_PPAUSE = 2, C_LOCK = 3, C_COMPL = 6, C_EPAUSE = 7;
  localparam int D_DUMMY = 0, D_DRIVE = 5;
  // protect modes and defaults
  localparam logic [1:0] GM_SOFT = 2'h0, GM_HW = 2'h1, GM_LOCKDOWN = 2'h2;
  localparam logic [1:0] DRIVE_RST = 2'h1;
  typedef enum logic [2:0] {OP_NONE, OP_PROG, OP_W4K, OP_W32K, OP_W64K, OP_CHIP, OP_STATUS} fswp_op_t;
endpackage : fswp_pkg
